// *** ahb_reg_port.sv ***
`timescale 1ns/10ps
module ahb_reg_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  reg_access_if.port bus
);
  typedef struct packed {
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
  } port_state_type;

  port_state_type s_r, s_nxt;
  logic accept;

  // zero wait states: read data is sampled in the address phase
  always_comb begin
    accept = hsel_i & htrans_i[1] & hready_i;
    s_nxt = s_r;
    s_nxt.ready = 1'b1;
    s_nxt.wr_pend = accept & hwrite_i;
    if (accept) begin
      s_nxt.wr_idx = haddr_i[11:2];
    end
    if (accept && !hwrite_i) begin
      s_nxt.rdata = bus.rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{wr_pend: 1'b0, wr_idx: 10'h000, rdata: 32'h00000000, ready: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.wr_stb = s_r.wr_pend;
  assign bus.wr_idx = s_r.wr_idx;
  assign bus.wr_data = hwdata_i;
  assign bus.rd_idx = haddr_i[11:2];
  assign hrdata_o = s_r.rdata;
  assign hreadyout_o = s_r.ready;
  assign hresp_o = 1'b0;

  a_ready_write: assert property (@(posedge clk_i) disable iff (rst_i)
    hsel_i && htrans_i[1] && hwrite_i |=> hreadyout_o && bus.wr_stb)
    else $error("write data phase not taken in one cycle");
endmodule : ahb_reg_port

// *** obyte_pkg.sv ***
package obyte_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] IDX_LVD_OPT = 10'h0C1;
  localparam logic [9:0] IDX_OSC_OPT = 10'h0C2;
  localparam logic [9:0] IDX_DBG_OPT = 10'h0C3;
  localparam logic [9:0] IDX_CTRL = 10'h0C4;
  localparam logic [9:0] IDX_STATUS = 10'h0C5;

  // ==========================================================================
  // option byte field positions
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  localparam int STEP_LSB = 2;
  localparam int PINSEL_BIT = 4;
  localparam int GROUP_LSB = 5;
  localparam int FMODE_LSB = 6;
  localparam int FREQ_LSB = 0;
  localparam int DBG_EN_BIT = 7;
  localparam int DBG_NOERASE_BIT = 0;
  localparam logic [1:0] STEP_LAST = 2'h3;

  // ==========================================================================
  // flash mode and oscillator codes
  localparam logic [1:0] FMODE_NONE = 2'h0;
  localparam logic [1:0] FMODE_LV = 2'h2;
  localparam logic [1:0] FMODE_HS = 2'h3;
  localparam logic [3:0] FRQ_24 = 4'h0;
  localparam logic [3:0] FRQ_16 = 4'h9;
  localparam logic [3:0] FRQ_12 = 4'h1;
  localparam logic [3:0] FRQ_8 = 4'hA;
  localparam logic [3:0] FRQ_4 = 4'hB;
  localparam logic [3:0] FRQ_1 = 4'hD;
  localparam logic [4:0] MHZ_24 = 5'h18;
  localparam logic [4:0] MHZ_16 = 5'h10;
  localparam logic [4:0] MHZ_12 = 5'h0C;
  localparam logic [4:0] MHZ_8 = 5'h08;
  localparam logic [4:0] MHZ_4 = 5'h04;
  localparam logic [4:0] MHZ_1 = 5'h01;
  localparam logic [4:0] MHZ_NONE = 5'h00;
  localparam logic [4:0] LV_MAX_MHZ = 5'h08;

  // ==========================================================================
  // control and status layout
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam logic CTRL_IRQ_EN_RESET = 1'h1;
  localparam int ERR_W = 5;
  localparam int ERR_LVD = 0;
  localparam int ERR_FMODE = 1;
  localparam int ERR_FREQ = 2;
  localparam int ERR_DBG = 3;
  localparam int ERR_RANGE = 4;
  localparam int ST_LOADED_BIT = 8;
  localparam int ST_BELOW_LO_BIT = 9;
  localparam int ST_BELOW_HI_BIT = 10;
  localparam int ST_MODE_LSB = 12;

  typedef enum logic [3:0] {
    LVD_OFF = 4'h1,
    LVD_INT = 4'h2,
    LVD_RST = 4'h4,
    LVD_BOTH = 4'h8
  } lvd_mode_type;

  typedef enum logic [2:0] {
    ST_FETCH = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } fsm_type;

endpackage : obyte_pkg

// *** option_byte_config_decoder.sv ***
// Behaviour
// - mode hi 0 lo 1 gives interrupt only; twelve group and step pairs valid.
// - lo 1 with group bit two 1 disables the detector, other bits ignored.
// - pin select 1 makes the pin a reset input with pull-up, else port.
// - flash mode 10 selects low voltage main, 1 to 8 MHz.
// - flash mode 11 selects high speed main; other encodings prohibited.
// - oscillator code picks 24, 16, 12, 8, 4 or 1 MHz; others prohibited.
// - debug enabled, no-erase set: debug allowed, failed check keeps flash.
// - debug enabled, no-erase clear: debug allowed, failed check erases flash.
// - both clear disables debug; enable 0 with no-erase 1 is prohibited.
// - both mode bits 1 gives reset mode; falling below threshold resets.
// - mode hi 1 lo 0 interrupts at the high pair, resets at the low.
`timescale 1ns/10ps
module option_byte_config_decoder (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic FLASH_RD_O,
  output logic [7:0] FLASH_ADDR_O,
  input wire logic [7:0] FLASH_DATA_I,
  input wire logic FLASH_ACK_I,
  input wire logic LVD_BELOW_LO_I,
  input wire logic LVD_BELOW_HI_I,
  input wire logic SEC_FAIL_I,
  output logic CPU_RUN_O,
  output logic [3:0] LVD_MODE_O,
  output logic [3:0] LVD_LEVEL_O,
  output logic LVD_IRQ_O,
  output logic LVD_RST_O,
  output logic PIN_IS_RESET_O,
  output logic PIN_PULLUP_O,
  output logic [1:0] FLASH_MODE_O,
  output logic [3:0] OSC_SEL_O,
  output logic [4:0] OSC_MHZ_O,
  output logic DEBUG_EN_O,
  output logic ERASE_ON_FAIL_O,
  output logic FLASH_ERASE_O,
  output logic [4:0] CFG_ERR_O
);
  // ==========================================================================
  // state
  typedef struct packed {
    obyte_pkg::fsm_type st;
    logic [1:0] idx_cnt;
    logic [7:0] lvd_opt;
    logic [7:0] osc_opt;
    logic [7:0] dbg_opt;
    logic irq_en;
    logic flash_rd;
    logic [7:0] flash_addr;
    logic cpu_run;
    obyte_pkg::lvd_mode_type lvd_mode;
    logic [3:0] lvd_level;
    logic lvd_irq;
    logic lvd_rst;
    logic pin_reset;
    logic [1:0] fmode;
    logic [3:0] osc_sel;
    logic [4:0] osc_mhz;
    logic dbg_en;
    logic erase_pol;
    logic erase_pulse;
    logic [obyte_pkg::ERR_W-1:0] err;
    logic lo_d;
    logic hi_d;
  } top_state_type;

  top_state_type s_r, s_nxt;
  reg_access_if rbus ();
  logic lo_sync;
  logic hi_sync;

  // decode terms
  logic [2:0] grp;
  logic [1:0] step;
  logic mode_hi;
  logic mode_lo;
  logic grp_ok;
  logic lvd_valid;
  obyte_pkg::lvd_mode_type mode_dec;
  logic [1:0] fmode_dec;
  logic [4:0] mhz_dec;
  logic freq_ok;
  logic dbg_en_dec;
  logic dbg_noerase;
  logic run;
  logic [31:0] status;

  // ==========================================================================
  // submodules
  ahb_reg_port u_port (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .hsel_i(HSEL_I),
    .haddr_i(HADDR_I),
    .htrans_i(HTRANS_I),
    .hwrite_i(HWRITE_I),
    .hwdata_i(HWDATA_I),
    .hready_i(HREADY_I),
    .hrdata_o(HRDATA_O),
    .hreadyout_o(HREADYOUT_O),
    .hresp_o(HRESP_O),
    .bus(rbus.port)
  );

  sync_agree #(.W(1)) u_sync_lo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(LVD_BELOW_LO_I),
    .q_o(lo_sync)
  );

  sync_agree #(.W(1)) u_sync_hi (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(LVD_BELOW_HI_I),
    .q_o(hi_sync)
  );

  // ==========================================================================
  // option byte decode
  always_comb begin
    grp = s_r.lvd_opt[obyte_pkg::GROUP_LSB +: 3];
    step = s_r.lvd_opt[obyte_pkg::STEP_LSB +: 2];
    mode_hi = s_r.lvd_opt[obyte_pkg::MODE_HI_BIT];
    mode_lo = s_r.lvd_opt[obyte_pkg::MODE_LO_BIT];
    grp_ok = (grp != 3'h0) && !grp[2];
    lvd_valid = 1'b0;
    mode_dec = obyte_pkg::LVD_OFF;
    if (mode_lo && grp[2]) begin
      lvd_valid = 1'b1;
    end else begin
      case ({mode_hi, mode_lo})
        2'h1: begin
          lvd_valid = grp_ok;
          mode_dec = obyte_pkg::LVD_INT;
        end
        2'h3: begin
          lvd_valid = grp_ok;
          mode_dec = obyte_pkg::LVD_RST;
        end
        // combined mode has no lowest step
        2'h2: begin
          lvd_valid = grp_ok && (step != obyte_pkg::STEP_LAST);
          mode_dec = obyte_pkg::LVD_BOTH;
        end
        default: begin
          lvd_valid = 1'b0;
        end
      endcase
      if (!lvd_valid) begin
        mode_dec = obyte_pkg::LVD_OFF;
      end
    end
    fmode_dec = s_r.osc_opt[obyte_pkg::FMODE_LSB +: 2];
    if (!fmode_dec[1]) begin
      fmode_dec = obyte_pkg::FMODE_NONE;
    end
    freq_ok = 1'b1;
    case (s_r.osc_opt[obyte_pkg::FREQ_LSB +: 4])
      obyte_pkg::FRQ_24: mhz_dec = obyte_pkg::MHZ_24;
      obyte_pkg::FRQ_16: mhz_dec = obyte_pkg::MHZ_16;
      obyte_pkg::FRQ_12: mhz_dec = obyte_pkg::MHZ_12;
      obyte_pkg::FRQ_8: mhz_dec = obyte_pkg::MHZ_8;
      obyte_pkg::FRQ_4: mhz_dec = obyte_pkg::MHZ_4;
      obyte_pkg::FRQ_1: mhz_dec = obyte_pkg::MHZ_1;
      default: begin
        mhz_dec = obyte_pkg::MHZ_NONE;
        freq_ok = 1'b0;
      end
    endcase
    dbg_en_dec = s_r.dbg_opt[obyte_pkg::DBG_EN_BIT];
    dbg_noerase = s_r.dbg_opt[obyte_pkg::DBG_NOERASE_BIT];
  end

  // ==========================================================================
  // register read mux
  always_comb begin
    status = 32'h00000000;
    status[obyte_pkg::ERR_W-1:0] = s_r.err;
    status[obyte_pkg::ST_LOADED_BIT] = s_r.cpu_run;
    status[obyte_pkg::ST_BELOW_LO_BIT] = lo_sync;
    status[obyte_pkg::ST_BELOW_HI_BIT] = hi_sync;
    status[obyte_pkg::ST_MODE_LSB +: 4] = s_r.lvd_mode;
    case (rbus.rd_idx)
      obyte_pkg::IDX_LVD_OPT: rbus.rd_data = {24'h000000, s_r.lvd_opt};
      obyte_pkg::IDX_OSC_OPT: rbus.rd_data = {24'h000000, s_r.osc_opt};
      obyte_pkg::IDX_DBG_OPT: rbus.rd_data = {24'h000000, s_r.dbg_opt};
      obyte_pkg::IDX_CTRL: begin
        // a write still in its data phase is forwarded so back-to-back reads see it
        if (rbus.wr_stb && rbus.wr_idx == obyte_pkg::IDX_CTRL) begin
          rbus.rd_data = {31'h00000000, rbus.wr_data[obyte_pkg::CTRL_IRQ_EN_BIT]};
        end else begin
          rbus.rd_data = {31'h00000000, s_r.irq_en};
        end
      end
      obyte_pkg::IDX_STATUS: rbus.rd_data = status;
      default: rbus.rd_data = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // load sequence and run-time behaviour
  always_comb begin
    s_nxt = s_r;
    run = (s_r.st == obyte_pkg::ST_RUN);
    s_nxt.flash_rd = 1'b0;
    if (rbus.wr_stb && rbus.wr_idx == obyte_pkg::IDX_CTRL) begin
      s_nxt.irq_en = rbus.wr_data[obyte_pkg::CTRL_IRQ_EN_BIT];
    end
    // one pass over the option bytes
    case (s_r.st)
      obyte_pkg::ST_FETCH: begin
        s_nxt.flash_rd = 1'b1;
        case (s_r.idx_cnt)
          2'h0: s_nxt.flash_addr = obyte_pkg::IDX_LVD_OPT[7:0];
          2'h1: s_nxt.flash_addr = obyte_pkg::IDX_OSC_OPT[7:0];
          default: s_nxt.flash_addr = obyte_pkg::IDX_DBG_OPT[7:0];
        endcase
        s_nxt.st = obyte_pkg::ST_WAIT;
      end
      obyte_pkg::ST_WAIT: begin
        if (FLASH_ACK_I) begin
          case (s_r.idx_cnt)
            2'h0: s_nxt.lvd_opt = FLASH_DATA_I;
            2'h1: s_nxt.osc_opt = FLASH_DATA_I;
            default: s_nxt.dbg_opt = FLASH_DATA_I;
          endcase
          if (s_r.idx_cnt == 2'h2) begin
            s_nxt.st = obyte_pkg::ST_RUN;
          end else begin
            s_nxt.idx_cnt = s_r.idx_cnt + 2'h1;
            s_nxt.st = obyte_pkg::ST_FETCH;
          end
        end
      end
      obyte_pkg::ST_RUN: begin
        s_nxt.st = obyte_pkg::ST_RUN;
      end
      default: begin
        s_nxt.st = obyte_pkg::ST_FETCH;
      end
    endcase
    // decoded settings only become visible once every byte is in
    s_nxt.cpu_run = run;
    s_nxt.lvd_mode = run ? mode_dec : obyte_pkg::LVD_OFF;
    s_nxt.lvd_level = run ? {grp[1:0], step} : 4'h0;
    s_nxt.pin_reset = run & s_r.lvd_opt[obyte_pkg::PINSEL_BIT];
    s_nxt.fmode = run ? fmode_dec : obyte_pkg::FMODE_NONE;
    s_nxt.osc_sel = run ? s_r.osc_opt[obyte_pkg::FREQ_LSB +: 4] : 4'h0;
    s_nxt.osc_mhz = run ? mhz_dec : obyte_pkg::MHZ_NONE;
    s_nxt.dbg_en = run & dbg_en_dec;
    s_nxt.erase_pol = run & dbg_en_dec & ~dbg_noerase;
    s_nxt.erase_pulse = run & SEC_FAIL_I & dbg_en_dec & ~dbg_noerase;
    s_nxt.err = '0;
    if (run) begin
      s_nxt.err[obyte_pkg::ERR_LVD] = ~lvd_valid;
      s_nxt.err[obyte_pkg::ERR_FMODE] = ~fmode_dec[1];
      s_nxt.err[obyte_pkg::ERR_FREQ] = ~freq_ok;
      s_nxt.err[obyte_pkg::ERR_DBG] = ~dbg_en_dec & dbg_noerase;
      // an oscillator faster than the low voltage mode allows is flagged too
      s_nxt.err[obyte_pkg::ERR_RANGE] = (fmode_dec == obyte_pkg::FMODE_LV) && (mhz_dec > obyte_pkg::LV_MAX_MHZ);
    end
    // interrupt on a new fall below the threshold
    s_nxt.lo_d = lo_sync;
    s_nxt.hi_d = hi_sync;
    s_nxt.lvd_irq = 1'b0;
    if (s_r.cpu_run && s_r.irq_en) begin
      if (s_r.lvd_mode == obyte_pkg::LVD_INT) begin
        s_nxt.lvd_irq = lo_sync & ~s_r.lo_d;
      end else if (s_r.lvd_mode == obyte_pkg::LVD_BOTH) begin
        s_nxt.lvd_irq = hi_sync & ~s_r.hi_d;
      end
    end
    // reset while below the low threshold
    s_nxt.lvd_rst = s_r.cpu_run && lo_sync &&
                    (s_r.lvd_mode == obyte_pkg::LVD_RST || s_r.lvd_mode == obyte_pkg::LVD_BOTH);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.st <= obyte_pkg::ST_FETCH;
      s_r.lvd_mode <= obyte_pkg::LVD_OFF;
      s_r.irq_en <= obyte_pkg::CTRL_IRQ_EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign FLASH_RD_O = s_r.flash_rd;
  assign FLASH_ADDR_O = s_r.flash_addr;
  assign CPU_RUN_O = s_r.cpu_run;
  assign LVD_MODE_O = s_r.lvd_mode;
  assign LVD_LEVEL_O = s_r.lvd_level;
  assign LVD_IRQ_O = s_r.lvd_irq;
  assign LVD_RST_O = s_r.lvd_rst;
  assign PIN_IS_RESET_O = s_r.pin_reset;
  assign PIN_PULLUP_O = s_r.pin_reset;
  assign FLASH_MODE_O = s_r.fmode;
  assign OSC_SEL_O = s_r.osc_sel;
  assign OSC_MHZ_O = s_r.osc_mhz;
  assign DEBUG_EN_O = s_r.dbg_en;
  assign ERASE_ON_FAIL_O = s_r.erase_pol;
  assign FLASH_ERASE_O = s_r.erase_pulse;
  assign CFG_ERR_O = s_r.err;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_int_only: assert property (LVD_MODE_O == obyte_pkg::LVD_INT |-> !LVD_RST_O)
    else $error("interrupt-only mode raised a reset");
  a_lvd_off: assert property (CPU_RUN_O && s_r.lvd_opt[0] && s_r.lvd_opt[7] |->
    LVD_MODE_O == obyte_pkg::LVD_OFF && !LVD_IRQ_O && !LVD_RST_O && !CFG_ERR_O[0])
    else $error("detector not off");
  a_pin_select: assert property (CPU_RUN_O |-> PIN_IS_RESET_O == s_r.lvd_opt[obyte_pkg::PINSEL_BIT]
    && PIN_PULLUP_O == s_r.lvd_opt[obyte_pkg::PINSEL_BIT])
    else $error("reset pin function wrong");
  a_flash_lv: assert property (CPU_RUN_O && s_r.osc_opt[7:6] == 2'h2 |-> FLASH_MODE_O == 2'h2)
    else $error("low voltage mode not selected");
  a_flash_bad: assert property (CPU_RUN_O && !s_r.osc_opt[7] |-> FLASH_MODE_O == 2'h0 && CFG_ERR_O[1])
    else $error("prohibited flash mode not flagged");
  a_freq_map: assert property (CPU_RUN_O && s_r.osc_opt[3:0] == 4'h9 |-> OSC_MHZ_O == 5'h10)
    else $error("oscillator code 1001 not 16 MHz");
  a_keep_flash: assert property (SEC_FAIL_I && s_r.dbg_opt[0] |=> !FLASH_ERASE_O)
    else $error("flash erased despite no-erase");
  a_erase_flash: assert property (CPU_RUN_O && SEC_FAIL_I && s_r.dbg_opt[7] && !s_r.dbg_opt[0]
    |=> FLASH_ERASE_O ##1 (!FLASH_ERASE_O || $past(SEC_FAIL_I)))
    else $error("failed check did not erase");
  a_dbg_bad: assert property (CPU_RUN_O && !s_r.dbg_opt[7] |-> !DEBUG_EN_O && CFG_ERR_O[3] == s_r.dbg_opt[0])
    else $error("debug disable or prohibited flag wrong");
  a_reset_mode: assert property (LVD_MODE_O == obyte_pkg::LVD_RST && lo_sync |=> LVD_RST_O)
    else $error("reset mode did not reset");
  a_both_irq: assert property (LVD_MODE_O == obyte_pkg::LVD_BOTH && s_r.irq_en && $rose(hi_sync)
    |=> LVD_IRQ_O)
    else $error("combined mode missed interrupt");
  a_load_static: assert property (s_r.st == obyte_pkg::ST_RUN |=> s_r.st == obyte_pkg::ST_RUN
    && $stable(s_r.lvd_opt) && $stable(s_r.osc_opt) && $stable(s_r.dbg_opt) && CPU_RUN_O)
    else $error("settings changed after load");
  a_err_lvd: assert property (CPU_RUN_O && s_r.lvd_opt[1:0] == 2'h0 && !s_r.lvd_opt[7] |-> CFG_ERR_O[0])
    else $error("prohibited detector mode not flagged");

  c_lvd_reset: cover property (LVD_RST_O);
  c_lvd_irq: cover property (LVD_IRQ_O);
  c_erase: cover property (FLASH_ERASE_O);
endmodule : option_byte_config_decoder

// *** option_byte_config_decoder_tb_top.sv ***
`timescale 1ns/10ps
module option_byte_config_decoder_tb_top;
  // ==========================================================================
  // signals
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, f_ack = 1'b0;
  logic below_lo = 1'b0, below_hi = 1'b0, sec_fail = 1'b0, stray = 1'b0, rdy_q = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [7:0] f_data = 8'h00, f_addr;
  logic hready, hresp, f_rd, cpu_run, lvd_irq, lvd_rst, pin_rst, pin_pu, dbg_en, ers_fail, f_erase;
  logic [3:0] lvd_mode, lvd_level, osc_sel, e_mode;
  logic [4:0] osc_mhz, cfg_err, e_err, e_mhz;
  logic [1:0] fmode, e_fm;
  logic [7:0] opt [3];
  logic [7:0] seen [$];
  int lat = 0, wcnt = -1, cycles = 0, error_cnt = 0, total_checks = 0;
  // detector/pin byte, flash mode/osc byte, debug byte
  logic [23:0] cfg [7] = '{24'h3DC085, 24'h638984, 24'h568A04, 24'hFF4B05, 24'h2ECD85, 24'h190F84, 24'h58C185};

  always #2 clk = ~clk;
  always @(negedge clk) rdy_q <= hready;

  option_byte_config_decoder u_dut (
    .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .FLASH_RD_O(f_rd), .FLASH_ADDR_O(f_addr), .FLASH_DATA_I(f_data), .FLASH_ACK_I(f_ack),
    .LVD_BELOW_LO_I(below_lo), .LVD_BELOW_HI_I(below_hi), .SEC_FAIL_I(sec_fail), .CPU_RUN_O(cpu_run),
    .LVD_MODE_O(lvd_mode), .LVD_LEVEL_O(lvd_level), .LVD_IRQ_O(lvd_irq), .LVD_RST_O(lvd_rst),
    .PIN_IS_RESET_O(pin_rst), .PIN_PULLUP_O(pin_pu), .FLASH_MODE_O(fmode), .OSC_SEL_O(osc_sel),
    .OSC_MHZ_O(osc_mhz), .DEBUG_EN_O(dbg_en), .ERASE_ON_FAIL_O(ers_fail), .FLASH_ERASE_O(f_erase),
    .CFG_ERR_O(cfg_err)
  );

  // ==========================================================================
  // option byte store; data line toggles whenever no answer is due
  // one answer per request, plus one unrequested answer whenever stray is set
  always @(posedge clk) begin
    f_ack <= 1'b0;
    f_data <= ~f_data;
    if (rst) begin
      wcnt = -1;
    end else begin
      if (f_rd === 1'b1) begin
        seen.push_back(f_addr);
        wcnt = lat;
      end
      if (wcnt == 0 || stray) begin
        f_ack <= 1'b1;
        f_data <= stray ? 8'h5A : opt[f_addr - 8'hC1];
        stray = 1'b0;
      end
      if (wcnt >= 0) wcnt--;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ==========================================================================
  // tasks
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy;
    @(posedge clk);
    while (rdy_q !== 1'b1) begin
      @(posedge clk);
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    #1;
    rd = hrdata;
    chk("response", 32'h0, hresp);
  endtask : ahb

  task automatic boot(input int k);
    int n;
    seen.delete();
    lat = k % 3;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ready in reset", 32'h1, hready);
    chk("mode in reset", 32'h1, lvd_mode);
    chk("run in reset", 32'h0, cpu_run);
    @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (cpu_run !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run", 32'h1, cpu_run);
    chk("fetch order", 32'hC1C2C3, {seen[0], seen[1], seen[2]});
  endtask : boot

  task automatic check_outputs;
    logic lo, hi, pin;
    logic [2:0] grp;
    logic [1:0] stp;
    {grp, pin, stp, hi, lo} = opt[0];
    e_err = 5'h00;
    e_mode = {hi, lo} == 2'h1 ? 4'h2 : {hi, lo} == 2'h3 ? 4'h4 : 4'h8;
    if (lo && grp[2]) begin
      e_mode = 4'h1;
    end else if (grp == 3'h0 || grp[2] || {hi, lo} == 2'h0 || ({hi, lo} == 2'h2 && stp == 2'h3)) begin
      e_mode = 4'h1;
      e_err[0] = 1'b1;
    end
    e_fm = opt[1][7] ? opt[1][7:6] : 2'h0;
    e_err[1] = !opt[1][7];
    case (opt[1][3:0])
      4'h0: e_mhz = 5'h18;
      4'h9: e_mhz = 5'h10;
      4'h1: e_mhz = 5'h0C;
      4'hA: e_mhz = 5'h08;
      4'hB: e_mhz = 5'h04;
      4'hD: e_mhz = 5'h01;
      default: e_mhz = 5'h00;
    endcase
    e_err[2] = e_mhz == 5'h00;
    e_err[3] = !opt[2][7] && opt[2][0];
    e_err[4] = e_fm == 2'h2 && e_mhz > 5'h08;
    chk("detector mode", e_mode, lvd_mode);
    if (e_mode != 4'h1) chk("level", {grp[1:0], stp}, lvd_level);
    chk("pin reset", pin, pin_rst);
    chk("pin pull-up", pin, pin_pu);
    chk("flash mode", e_fm, fmode);
    chk("osc code", opt[1][3:0], osc_sel);
    chk("osc mhz", e_mhz, osc_mhz);
    chk("debug", opt[2][7], dbg_en);
    chk("erase policy", opt[2][7] && !opt[2][0], ers_fail);
    chk("errors", e_err, cfg_err);
  endtask : check_outputs

  task automatic probe(input logic lo, input logic en);
    int irqs;
    irqs = 0;
    @(posedge clk);
    below_hi <= 1'b1;
    below_lo <= lo;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (lvd_irq !== 1'b0) irqs++;
    end
    chk("irq count", en && (e_mode == 4'h8 || (lo && e_mode == 4'h2)), irqs);
    chk("reset level", lo && (e_mode == 4'h4 || e_mode == 4'h8), lvd_rst);
    @(posedge clk);
    below_hi <= 1'b0;
    below_lo <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk("reset released", 32'h0, lvd_rst);
  endtask : probe

  task automatic sec_check;
    int n;
    n = 0;
    @(posedge clk);
    sec_fail <= 1'b1;
    repeat (4) begin
      @(posedge clk);
      sec_fail <= 1'b0;
      #1;
      if (f_erase !== 1'b0) n++;
    end
    chk("erase pulses", opt[2][7] && !opt[2][0], n);
  endtask : sec_check

  // ==========================================================================
  // main sequence
  initial begin
    for (int k = 0; k < 7; k++) begin
      {opt[0], opt[1], opt[2]} = cfg[k];
      boot(k);
      // a late answer with other data must not be taken
      stray = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("fetch count", 32'h3, seen.size());
      check_outputs();
      probe(1'b0, 1'b1);
      probe(1'b1, 1'b1);
      sec_check();
      if (k == 0) begin
        ahb(1'b0, 12'h310, 32'h0);
        chk("control reset", 32'h1, rd);
        ahb(1'b1, 12'h304, 32'hFFFFFFFF);
        ahb(1'b0, 12'h400, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 12'h310, 32'h0);
        ahb(1'b0, 12'h310, 32'h0);
        chk("control", 32'h0, rd);
        probe(1'b1, 1'b0);
      end
      for (int i = 0; i < 3; i++) begin
        ahb(1'b0, 12'h304 + 12'(4 * i), 32'h0);
        chk("option byte", {24'h0, opt[i]}, rd);
      end
      ahb(1'b0, 12'h314, 32'h0);
      chk("status", {16'h0, e_mode, 3'h0, 1'b1, 3'h0, e_err}, rd);
    end
    print_verdict();
  end
endmodule : option_byte_config_decoder_tb_top

// *** reg_access_if.sv ***
`timescale 1ns/10ps
interface reg_access_if;
  logic wr_stb;
  logic [9:0] wr_idx;
  logic [31:0] wr_data;
  logic [9:0] rd_idx;
  logic [31:0] rd_data;
  modport port (output wr_stb, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_stb, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : reg_access_if

// *** sync_agree.sv ***
`timescale 1ns/10ps
module sync_agree #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s0;
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] q;
  } sync_state_type;

  sync_state_type s_r, s_nxt;

  if (W < 1) begin : g_chk
    $error("sync_agree needs W of at least one");
  end

  // a change counts only once the second and third stages agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s0 = d_i;
    s_nxt.s1 = s_r.s0;
    s_nxt.s2 = s_r.s1;
    for (int i = 0; i < W; i++) begin
      if (s_r.s1[i] == s_r.s2[i]) begin
        s_nxt.q[i] = s_r.s2[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;
endmodule : sync_agree
